// ---- hdl/uart_page_pkg.sv ----
package uart_page_pkg;

  // ==========================================================================
  // addresses
  localparam logic [2:0] ADDR_HOLD = 3'h0;
  localparam logic [2:0] ADDR_INT_EN = 3'h1;
  localparam logic [2:0] ADDR_INT_STAT = 3'h2;
  localparam logic [2:0] ADDR_LINE_CTRL = 3'h3;
  localparam logic [2:0] ADDR_MODEM_CTRL = 3'h4;
  localparam logic [2:0] ADDR_LINE_STAT = 3'h5;
  localparam logic [2:0] ADDR_MODEM_STAT = 3'h6;
  localparam logic [2:0] ADDR_SCRATCH = 3'h7;

  // ==========================================================================
  // field positions and masks
  localparam logic [7:0] ENH_PAGE_KEY = 8'hBF;
  localparam int LINE_CTRL_DIV_BIT = 7;
  localparam int ENH_EN_BIT = 4;
  localparam int FIFO_EN_BIT = 0;
  localparam int FIFO_RX_RST_BIT = 1;
  localparam int FIFO_TX_RST_BIT = 2;
  localparam logic [7:0] INT_EN_ENH_MASK = 8'hF0;
  localparam logic [7:0] FIFO_ENH_MASK = 8'h30;
  localparam logic [7:0] FIFO_PULSE_MASK = 8'h06;
  localparam logic [7:0] MODEM_CTRL_ENH_MASK = 8'hE0;
  localparam logic [5:0] INT_STAT_ENH_MASK = 6'h30;

  // ==========================================================================
  // values after reset
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [3:0] NIBBLE_RESET = 4'h0;
  // identity values are arbitrary
  localparam logic [7:0] REVISION_CODE = 8'h01;
  localparam logic [7:0] IDENT_CODE = 8'h5A;

  typedef enum logic [4:0] {
    TGT_NONE, TGT_RX_HOLD, TGT_TX_HOLD, TGT_DIV_LOW, TGT_DIV_HIGH, TGT_REVISION,
    TGT_IDENT, TGT_INT_ENABLE, TGT_INT_STATUS, TGT_FIFO_CTRL, TGT_LINE_CTRL,
    TGT_MODEM_CTRL, TGT_LINE_STATUS, TGT_EXTRA, TGT_MODEM_STATUS, TGT_IR_WIDTH,
    TGT_SCRATCH, TGT_ENH_FUNC, TGT_FLOW_ON_ONE, TGT_FLOW_ON_TWO,
    TGT_FLOW_OFF_ONE, TGT_FLOW_OFF_TWO
  } reg_target_type;

endpackage

// ---- hdl/page_sel_if.sv ----
`timescale 1ns/1ps
interface page_sel_if;
  import uart_page_pkg::*;
  logic [2:0] addr;
  logic [7:0] line_ctrl;
  logic enh_en;
  logic div_zero;
  reg_target_type rd_target;
  reg_target_type wr_target;

  modport decoder (
    input addr, line_ctrl, enh_en, div_zero,
    output rd_target, wr_target
  );
  modport bank (
    output addr, line_ctrl, enh_en, div_zero,
    input rd_target, wr_target
  );
endinterface

// ---- hdl/page_decode.sv ----
`timescale 1ns/1ps
module page_decode
  import uart_page_pkg::*;
(
  page_sel_if.decoder sel
);

  // ==========================================================================
  // page selection, shared by read and write
  function automatic reg_target_type page_target(
    input logic [2:0] addr,
    input logic [7:0] line_ctrl,
    input logic enh,
    input logic div_zero,
    input logic is_write
  );
    reg_target_type t;
    t = TGT_NONE;
    if (addr == ADDR_LINE_CTRL)
      t = TGT_LINE_CTRL;
    else if (line_ctrl == ENH_PAGE_KEY)
    begin
      case (addr)
        ADDR_INT_STAT: t = TGT_ENH_FUNC;
        ADDR_MODEM_CTRL: t = TGT_FLOW_ON_ONE;
        ADDR_LINE_STAT: t = TGT_FLOW_ON_TWO;
        ADDR_MODEM_STAT: t = TGT_FLOW_OFF_ONE;
        ADDR_SCRATCH: t = TGT_FLOW_OFF_TWO;
        default: t = TGT_NONE;
      endcase
    end
    else if (line_ctrl[LINE_CTRL_DIV_BIT])
    begin
      if (addr == ADDR_HOLD)
        t = (div_zero && !is_write) ? TGT_REVISION : TGT_DIV_LOW;
      else if (addr == ADDR_INT_EN)
        t = (div_zero && !is_write) ? TGT_IDENT : TGT_DIV_HIGH;
    end
    else
    begin
      case (addr)
        ADDR_HOLD: t = is_write ? TGT_TX_HOLD : TGT_RX_HOLD;
        ADDR_INT_EN: t = TGT_INT_ENABLE;
        ADDR_INT_STAT: t = is_write ? TGT_FIFO_CTRL : TGT_INT_STATUS;
        ADDR_MODEM_CTRL: t = TGT_MODEM_CTRL;
        ADDR_LINE_STAT: t = is_write ? (enh ? TGT_EXTRA : TGT_NONE) : TGT_LINE_STATUS;
        ADDR_MODEM_STAT: t = is_write ? (enh ? TGT_IR_WIDTH : TGT_NONE) : TGT_MODEM_STATUS;
        ADDR_SCRATCH: t = TGT_SCRATCH;
        default: t = TGT_NONE;
      endcase
    end
    return t;
  endfunction

  always_comb
  begin
    sel.rd_target = page_target(sel.addr, sel.line_ctrl, sel.enh_en, sel.div_zero, 1'b0);
    sel.wr_target = page_target(sel.addr, sel.line_ctrl, sel.enh_en, sel.div_zero, 1'b1);
  end

endmodule

// ---- hdl/modem_change_track.sv ----
`timescale 1ns/1ps
module modem_change_track
  import uart_page_pkg::*;
(
  // clock and reset
  input wire logic i_clk,
  input wire logic i_reset,
  // modem lines and clear
  input wire logic [3:0] i_lines,
  input wire logic i_clear,
  output logic [3:0] o_delta
);

  logic [3:0] prev_r;
  logic [3:0] delta_r;
  logic [3:0] delta_nxt;

  // a change seen in the clearing cycle is kept: set wins
  always_comb
  begin
    delta_nxt = (i_clear ? NIBBLE_RESET : delta_r) | (i_lines ^ prev_r);
  end

  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      prev_r <= NIBBLE_RESET;
      delta_r <= NIBBLE_RESET;
    end
    else
    begin
      prev_r <= i_lines;
      delta_r <= delta_nxt;
    end
  end

  assign o_delta = delta_r;

endmodule

// ---- hdl/uart_register_page_decode.sv ----
`timescale 1ns/1ps
module uart_register_page_decode
  import uart_page_pkg::*;
(
  // clock and reset
  input wire logic i_clk,
  input wire logic i_reset,
  // host register bus
  input wire logic [2:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  output logic o_rdata_valid,
  // serial engine status
  input wire logic [7:0] i_rx_char,
  input wire logic [5:0] i_int_source,
  input wire logic [7:0] i_line_status,
  input wire logic [3:0] i_modem_lines,
  // serial engine data strobes
  output logic [7:0] o_tx_char,
  output logic o_tx_load,
  output logic o_rx_pop,
  output logic o_rx_fifo_reset,
  output logic o_tx_fifo_reset,
  // configuration
  output logic [15:0] o_divisor,
  output logic [7:0] o_interrupt_enable,
  output logic [7:0] o_fifo_control,
  output logic [7:0] o_line_control,
  output logic [7:0] o_modem_control,
  output logic [7:0] o_enhanced_function,
  output logic [7:0] o_extra_feature,
  output logic [7:0] o_infrared_pulse_width,
  output logic [7:0] o_flow_on_one,
  output logic [7:0] o_flow_on_two,
  output logic [7:0] o_flow_off_one,
  output logic [7:0] o_flow_off_two
);

  // ==========================================================================
  // storage
  logic [7:0] div_low_r;
  logic [7:0] div_high_r;
  logic [7:0] int_enable_r;
  logic [7:0] fifo_control_r;
  logic [7:0] line_control_r;
  logic [7:0] modem_control_r;
  logic [7:0] enh_function_r;
  logic [7:0] extra_feature_r;
  logic [7:0] ir_width_r;
  logic [7:0] scratch_r;
  logic [7:0] flow_on_one_r;
  logic [7:0] flow_on_two_r;
  logic [7:0] flow_off_one_r;
  logic [7:0] flow_off_two_r;
  logic [7:0] tx_char_r;
  logic tx_load_r;
  logic rx_pop_r;
  logic rx_fifo_reset_r;
  logic tx_fifo_reset_r;
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;
  logic rdata_valid_r;
  logic [3:0] modem_delta;
  logic enh_en;
  logic enh_drop;
  logic [7:0] enh_keep;
  reg_target_type rd_sel;
  reg_target_type wr_sel;

  // ==========================================================================
  // page decode
  page_sel_if sel ();

  assign sel.addr = i_addr;
  assign sel.line_ctrl = line_control_r;
  assign sel.enh_en = enh_en;
  // zero divisor swaps in identity reads
  assign sel.div_zero = (div_low_r == REG_RESET) && (div_high_r == REG_RESET);

  page_decode u_decode (
    .sel(sel.decoder)
  );

  assign rd_sel = i_rd ? sel.rd_target : TGT_NONE;
  assign wr_sel = i_wr ? sel.wr_target : TGT_NONE;

  // enhanced enable and its falling write
  assign enh_en = enh_function_r[ENH_EN_BIT];
  assign enh_drop = (wr_sel == TGT_ENH_FUNC) && !i_wdata[ENH_EN_BIT];
  assign enh_keep = enh_en ? 8'hFF : 8'h00;

  // ==========================================================================
  // modem change flags
  modem_change_track u_modem (
    .i_clk(i_clk),
    .i_reset(i_reset),
    .i_lines(i_modem_lines),
    .i_clear(rd_sel == TGT_MODEM_STATUS),
    .o_delta(modem_delta)
  );

  // ==========================================================================
  // divisor
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      div_low_r <= REG_RESET;
      div_high_r <= REG_RESET;
    end
    else
    begin
      if (wr_sel == TGT_DIV_LOW)
        div_low_r <= i_wdata;
      if (wr_sel == TGT_DIV_HIGH)
        div_high_r <= i_wdata;
    end
  end

  // ==========================================================================
  // base page control registers
  // clearing the enhanced enable also clears the enhanced bits, so the
  // engine never acts on settings software can no longer see
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
      int_enable_r <= REG_RESET;
    else if (wr_sel == TGT_INT_ENABLE)
      int_enable_r <= i_wdata & (~INT_EN_ENH_MASK | enh_keep);
    else if (enh_drop)
      int_enable_r <= int_enable_r & ~INT_EN_ENH_MASK;
  end

  always_ff @(posedge i_clk)
  begin
    if (i_reset)
      fifo_control_r <= REG_RESET;
    // reset bits are pulses, not stored
    else if (wr_sel == TGT_FIFO_CTRL)
      fifo_control_r <= i_wdata & ~FIFO_PULSE_MASK & (~FIFO_ENH_MASK | enh_keep);
    else if (enh_drop)
      fifo_control_r <= fifo_control_r & ~FIFO_ENH_MASK;
  end

  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      rx_fifo_reset_r <= 1'b0;
      tx_fifo_reset_r <= 1'b0;
    end
    else
    begin
      rx_fifo_reset_r <= (wr_sel == TGT_FIFO_CTRL) && i_wdata[FIFO_RX_RST_BIT];
      tx_fifo_reset_r <= (wr_sel == TGT_FIFO_CTRL) && i_wdata[FIFO_TX_RST_BIT];
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_reset)
      line_control_r <= REG_RESET;
    else if (wr_sel == TGT_LINE_CTRL)
      line_control_r <= i_wdata;
  end

  always_ff @(posedge i_clk)
  begin
    if (i_reset)
      modem_control_r <= REG_RESET;
    else if (wr_sel == TGT_MODEM_CTRL)
      modem_control_r <= i_wdata & (~MODEM_CTRL_ENH_MASK | enh_keep);
    else if (enh_drop)
      modem_control_r <= modem_control_r & ~MODEM_CTRL_ENH_MASK;
  end

  always_ff @(posedge i_clk)
  begin
    if (i_reset)
      scratch_r <= REG_RESET;
    else if (wr_sel == TGT_SCRATCH)
      scratch_r <= i_wdata;
  end

  // ==========================================================================
  // enhanced-gated write-only registers
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      extra_feature_r <= REG_RESET;
      ir_width_r <= REG_RESET;
    end
    else
    begin
      if (wr_sel == TGT_EXTRA)
        extra_feature_r <= i_wdata;
      if (wr_sel == TGT_IR_WIDTH)
        ir_width_r <= i_wdata;
    end
  end

  // ==========================================================================
  // enhanced page
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
      enh_function_r <= REG_RESET;
    else if (wr_sel == TGT_ENH_FUNC)
      enh_function_r <= i_wdata;
  end

  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      flow_on_one_r <= REG_RESET;
      flow_on_two_r <= REG_RESET;
      flow_off_one_r <= REG_RESET;
      flow_off_two_r <= REG_RESET;
    end
    else
    begin
      if (wr_sel == TGT_FLOW_ON_ONE)
        flow_on_one_r <= i_wdata;
      if (wr_sel == TGT_FLOW_ON_TWO)
        flow_on_two_r <= i_wdata;
      if (wr_sel == TGT_FLOW_OFF_ONE)
        flow_off_one_r <= i_wdata;
      if (wr_sel == TGT_FLOW_OFF_TWO)
        flow_off_two_r <= i_wdata;
    end
  end

  // ==========================================================================
  // character strobes
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      tx_char_r <= REG_RESET;
      tx_load_r <= 1'b0;
      rx_pop_r <= 1'b0;
    end
    else
    begin
      tx_load_r <= (wr_sel == TGT_TX_HOLD);
      rx_pop_r <= (rd_sel == TGT_RX_HOLD);
      if (wr_sel == TGT_TX_HOLD)
        tx_char_r <= i_wdata;
    end
  end

  // ==========================================================================
  // read mux
  always_comb
  begin
    rdata_nxt = REG_RESET;
    case (rd_sel)
      TGT_RX_HOLD: rdata_nxt = i_rx_char;
      TGT_DIV_LOW: rdata_nxt = div_low_r;
      TGT_DIV_HIGH: rdata_nxt = div_high_r;
      TGT_REVISION: rdata_nxt = REVISION_CODE;
      TGT_IDENT: rdata_nxt = IDENT_CODE;
      TGT_INT_ENABLE: rdata_nxt = int_enable_r & (~INT_EN_ENH_MASK | enh_keep);
      TGT_INT_STATUS: rdata_nxt = {{2{fifo_control_r[FIFO_EN_BIT]}},
                                   i_int_source & (~INT_STAT_ENH_MASK | enh_keep[5:0])};
      TGT_LINE_CTRL: rdata_nxt = line_control_r;
      TGT_MODEM_CTRL: rdata_nxt = modem_control_r & (~MODEM_CTRL_ENH_MASK | enh_keep);
      TGT_LINE_STATUS: rdata_nxt = i_line_status;
      TGT_MODEM_STATUS: rdata_nxt = {i_modem_lines, modem_delta};
      TGT_SCRATCH: rdata_nxt = scratch_r;
      TGT_ENH_FUNC: rdata_nxt = enh_function_r;
      TGT_FLOW_ON_ONE: rdata_nxt = flow_on_one_r;
      TGT_FLOW_ON_TWO: rdata_nxt = flow_on_two_r;
      TGT_FLOW_OFF_ONE: rdata_nxt = flow_off_one_r;
      TGT_FLOW_OFF_TWO: rdata_nxt = flow_off_two_r;
      default: rdata_nxt = REG_RESET;
    endcase
  end

  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      rdata_r <= REG_RESET;
      rdata_valid_r <= 1'b0;
    end
    else
    begin
      rdata_valid_r <= i_rd;
      if (i_rd)
        rdata_r <= rdata_nxt;
    end
  end

  // ==========================================================================
  // outputs
  assign o_rdata = rdata_r;
  assign o_rdata_valid = rdata_valid_r;
  assign o_tx_char = tx_char_r;
  assign o_tx_load = tx_load_r;
  assign o_rx_pop = rx_pop_r;
  assign o_rx_fifo_reset = rx_fifo_reset_r;
  assign o_tx_fifo_reset = tx_fifo_reset_r;
  assign o_divisor = {div_high_r, div_low_r};
  assign o_interrupt_enable = int_enable_r;
  assign o_fifo_control = fifo_control_r;
  assign o_line_control = line_control_r;
  assign o_modem_control = modem_control_r;
  assign o_enhanced_function = enh_function_r;
  assign o_extra_feature = extra_feature_r;
  assign o_infrared_pulse_width = ir_width_r;
  assign o_flow_on_one = flow_on_one_r;
  assign o_flow_on_two = flow_on_two_r;
  assign o_flow_off_one = flow_off_one_r;
  assign o_flow_off_two = flow_off_two_r;

endmodule

// ---- sim/page_decode_checker.sv ----
`timescale 1ns/1ps
module page_decode_checker
  import uart_page_pkg::*;
(
  // clock and reset
  input wire logic i_clk,
  input wire logic i_reset,
  // host bus
  input wire logic [2:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [7:0] o_rdata,
  input wire logic o_rdata_valid,
  // engine side
  input wire logic [7:0] i_line_status,
  input wire logic [7:0] o_tx_char,
  input wire logic o_tx_load,
  input wire logic o_rx_pop,
  input wire logic o_rx_fifo_reset,
  // configuration
  input wire logic [15:0] o_divisor,
  input wire logic [7:0] o_interrupt_enable,
  input wire logic [7:0] o_line_control,
  input wire logic [7:0] o_enhanced_function
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_reset);
  logic base_pg;
  logic div_pg;
  assign base_pg = !o_line_control[LINE_CTRL_DIV_BIT];
  assign div_pg = !base_pg && (o_line_control != ENH_PAGE_KEY);
  // ====================================================================
  // bus timing and decode
  a_read_answer: assert property (i_rd |=> o_rdata_valid)
    else $error("read not answered next cycle");
  a_no_idle_answer: assert property (!i_rd |=> !o_rdata_valid)
    else $error("answer without read");
  a_tx_load_cause: assert property (
    o_tx_load |-> $past(i_wr && i_addr == ADDR_HOLD && base_pg))
    else $error("transmit load without base write");
  a_tx_char_value: assert property (o_tx_load |-> o_tx_char == $past(i_wdata))
    else $error("transmit char differs from written");
  a_rx_pop_read: assert property (
    (i_rd && i_addr == ADDR_HOLD && base_pg) |=> o_rx_pop)
    else $error("receive read gave no pop");
  a_line_status_pass: assert property (
    (i_rd && i_addr == ADDR_LINE_STAT && base_pg) |=> o_rdata == $past(i_line_status))
    else $error("line status read wrong");
  a_line_ctrl_update: assert property (
    (i_wr && i_addr == ADDR_LINE_CTRL) |=> o_line_control == $past(i_wdata))
    else $error("line control not written");
  a_enh_gating: assert property (
    !o_enhanced_function[ENH_EN_BIT] |-> (o_interrupt_enable & INT_EN_ENH_MASK) == 8'h00)
    else $error("enhanced enable bits kept while gated");
  a_ident_subst: assert property (
    (i_rd && i_addr == ADDR_INT_EN && div_pg && o_divisor == 16'h0000)
    |=> o_rdata == IDENT_CODE)
    else $error("identification not substituted");
  a_fifo_reset: assert property (
    (i_wr && i_addr == ADDR_INT_STAT && base_pg && i_wdata[FIFO_RX_RST_BIT])
    |=> o_rx_fifo_reset)
    else $error("receive fifo reset not pulsed");
  a_unmapped_zero: assert property (
    (i_rd && i_addr == ADDR_HOLD && o_line_control == ENH_PAGE_KEY) |=> o_rdata == 8'h00)
    else $error("unmapped read not zero");
  c_enh_write: cover property (
    i_wr && i_addr == ADDR_INT_STAT && o_line_control == ENH_PAGE_KEY);
  c_tx_load: cover property (o_tx_load);
  c_ident_read: cover property (o_rdata_valid && o_rdata == IDENT_CODE);
endmodule

bind uart_register_page_decode page_decode_checker chk (
  .i_clk, .i_reset, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .o_rdata_valid,
  .i_line_status, .o_tx_char, .o_tx_load, .o_rx_pop, .o_rx_fifo_reset,
  .o_divisor, .o_interrupt_enable, .o_line_control, .o_enhanced_function
);

// ---- sim/host_model.sv ----
`timescale 1ns/1ps
module host_model
(
  // clock
  input wire logic i_clk,
  // host bus
  output logic [2:0] o_addr,
  output logic [7:0] o_wdata,
  output logic o_wr,
  output logic o_rd,
  input wire logic [7:0] i_rdata,
  input wire logic i_rdata_valid
);
  initial
  begin
    o_addr = 3'h0;
    o_wdata = 8'h00;
    o_wr = 1'b0;
    o_rd = 1'b0;
  end
  // three-bit select
  // released data shows the inverse so a stale value never looks valid
  task automatic write_reg(input logic [2:0] a, input logic [7:0] d);
    @(posedge i_clk);
    o_addr <= a;
    o_wdata <= d;
    o_wr <= 1'b1;
    @(posedge i_clk);
    o_wr <= 1'b0;
    o_wdata <= ~d;
    #1;
  endtask
  task automatic read_reg(input logic [2:0] a, output logic [7:0] d, output logic v);
    @(posedge i_clk);
    o_addr <= a;
    o_rd <= 1'b1;
    @(posedge i_clk);
    o_rd <= 1'b0;
    // the answer stands for the cycle after the read edge; take it 1 ns after that edge
    #1;
    d = i_rdata;
    v = i_rdata_valid;
  endtask
  task automatic set_page(input logic [7:0] pg);
    write_reg(3'h3, pg);
  endtask
endmodule

// ---- sim/testbench.sv ----
`timescale 1ns/1ps
module testbench;
  import uart_page_pkg::*;
  logic i_clk, i_reset, i_wr, i_rd, o_rdata_valid, o_tx_load, o_rx_pop;
  logic o_rx_fifo_reset, o_tx_fifo_reset;
  logic [2:0] i_addr;
  logic [5:0] i_int_source;
  logic [3:0] i_modem_lines;
  logic [15:0] o_divisor;
  logic [7:0] i_wdata, i_rx_char, i_line_status, o_rdata, o_tx_char, o_interrupt_enable;
  logic [7:0] o_fifo_control, o_line_control, o_modem_control, o_enhanced_function;
  logic [7:0] o_extra_feature, o_infrared_pulse_width, o_flow_on_one, o_flow_on_two;
  logic [7:0] o_flow_off_one, o_flow_off_two, v, w;
  logic [31:0] lfsr_r;
  int fail_count, n_tests, cycles;
  uart_register_page_decode DUT (.*);
  host_model host (.i_clk, .o_addr(i_addr), .o_wdata(i_wdata), .o_wr(i_wr), .o_rd(i_rd),
    .i_rdata(o_rdata), .i_rdata_valid(o_rdata_valid));
  initial
  begin
    i_clk = 1'b0;
    forever #2 i_clk = ~i_clk;
  end
  // ====================================================================
  // helpers
  function automatic logic [7:0] int_status_exp(input logic f, input logic [5:0] s,
                                                input logic e);
    return {f, f, e ? s : (s & ~INT_STAT_ENH_MASK)};
  endfunction
  // lfsr keeps the stream repeatable from the fixed seed
  function automatic logic [7:0] next_rand();
    lfsr_r = {lfsr_r[30:0], lfsr_r[31] ^ lfsr_r[21] ^ lfsr_r[1] ^ lfsr_r[0]};
    return lfsr_r[7:0];
  endfunction
  function automatic logic [7:0] flow_reg(input int a);
    case (a)
      4: return o_flow_on_one;
      5: return o_flow_on_two;
      6: return o_flow_off_one;
      default: return o_flow_off_two;
    endcase
  endfunction
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic rd_chk(input logic [2:0] a, input logic [7:0] exp);
    logic [7:0] d;
    logic ok;
    host.read_reg(a, d, ok);
    check({7'h00, ok}, 8'h01);
    check(d, exp);
  endtask
  task automatic engine_new;
    logic [7:0] r;
    r = next_rand();
    @(posedge i_clk);
    i_rx_char <= r;
    i_int_source <= r[7:2];
    i_line_status <= ~r;
    #1;
  endtask
  task automatic end_of_test;
    if (fail_count == 0 && n_tests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // the sequence needs about 110 cycles; the ceiling leaves wide margin
  always @(posedge i_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 2000)
    begin
      fail_count++;
      end_of_test();
    end
  end
  // ====================================================================
  // sequence
  initial
  begin
    {i_reset, i_rx_char, i_int_source, i_line_status, i_modem_lines} = 27'h4000000;
    {lfsr_r, fail_count, n_tests, cycles} = {32'h5967F0BE, 96'h0};
    repeat (2) @(posedge i_clk);
    i_reset <= 1'b0;
    rd_chk(ADDR_LINE_CTRL, 8'h00);
    engine_new();
    rd_chk(ADDR_HOLD, i_rx_char);
    v = next_rand();
    host.write_reg(ADDR_HOLD, v);
    check(o_tx_char, v);
    for (int i = 0; i < 4; i++)
    begin
      v = next_rand();
      host.write_reg(ADDR_SCRATCH, (i == 0) ? 8'hFF : v);
      rd_chk(ADDR_SCRATCH, (i == 0) ? 8'hFF : v);
    end
    host.write_reg(ADDR_INT_EN, 8'hFF);
    rd_chk(ADDR_INT_EN, 8'h0F);
    check(o_interrupt_enable, 8'h0F);
    host.write_reg(ADDR_MODEM_CTRL, 8'hFF);
    rd_chk(ADDR_MODEM_CTRL, 8'h1F);
    check(o_modem_control, 8'h1F);
    host.write_reg(ADDR_INT_STAT, 8'hF7);
    check({6'h00, o_rx_fifo_reset, o_tx_fifo_reset}, 8'h03);
    check(o_fifo_control, 8'hC1);
    engine_new();
    rd_chk(ADDR_INT_STAT, int_status_exp(1'b1, i_int_source, 1'b0));
    rd_chk(ADDR_LINE_STAT, i_line_status);
    @(posedge i_clk);
    i_modem_lines <= 4'hA;
    rd_chk(ADDR_MODEM_STAT, 8'hAA);
    rd_chk(ADDR_MODEM_STAT, 8'hA0);
    host.set_page(8'h80);
    rd_chk(ADDR_HOLD, REVISION_CODE);
    rd_chk(ADDR_INT_EN, IDENT_CODE);
    v = next_rand();
    host.write_reg(ADDR_HOLD, v | 8'h01);
    host.write_reg(ADDR_INT_EN, 8'h3C);
    rd_chk(ADDR_HOLD, v | 8'h01);
    rd_chk(ADDR_INT_EN, 8'h3C);
    check(o_divisor[7:0], v | 8'h01);
    check(o_divisor[15:8], 8'h3C);
    rd_chk(ADDR_INT_STAT, 8'h00);
    host.set_page(ENH_PAGE_KEY);
    rd_chk(ADDR_LINE_CTRL, 8'hBF);
    host.write_reg(ADDR_INT_STAT, 8'h10);
    rd_chk(ADDR_INT_STAT, 8'h10);
    check(o_enhanced_function, 8'h10);
    for (int a = 4; a < 8; a++)
    begin
      v = next_rand();
      host.write_reg(3'(a), v);
      rd_chk(3'(a), v);
      check(flow_reg(a), v);
    end
    rd_chk(ADDR_HOLD, 8'h00);
    host.set_page(8'h03);
    host.write_reg(ADDR_INT_EN, 8'hFF);
    rd_chk(ADDR_INT_EN, 8'hFF);
    v = next_rand();
    w = next_rand();
    host.write_reg(ADDR_LINE_STAT, v);
    host.write_reg(ADDR_MODEM_STAT, w);
    check(o_extra_feature, v);
    check(o_infrared_pulse_width, w);
    engine_new();
    rd_chk(ADDR_INT_STAT, int_status_exp(1'b1, i_int_source, 1'b1));
    host.set_page(ENH_PAGE_KEY);
    host.write_reg(ADDR_INT_STAT, 8'h00);
    host.set_page(8'h03);
    rd_chk(ADDR_INT_EN, 8'h0F);
    check(o_interrupt_enable, 8'h0F);
    host.write_reg(ADDR_LINE_STAT, ~v);
    check(o_extra_feature, v);
    end_of_test();
  end
endmodule
